// file: verilog/bl_regs.vh
`ifndef BL_REGS_VH
`define BL_REGS_VH

// Register addresses
`define BL_ADDR_MODE      8'h01
`define BL_ADDR_FADE      8'h03
`define BL_ADDR_LAW       8'h04
`define BL_ADDR_SINK_EN   8'h05
`define BL_ADDR_MAX       8'h09
`define BL_ADDR_DIM       8'h0a
`define BL_ADDR_STATUS    8'h0b
`define BL_ADDR_CODE      8'h0c

// Mode control bit positions
`define BL_MODE_ACTIVE    0
`define BL_MODE_BL_ON     1
`define BL_MODE_DIM       2

// Status bit positions
`define BL_STAT_STANDBY   0
`define BL_STAT_PRECHARGE 1
`define BL_STAT_GAIN_LO   2
`define BL_STAT_GAIN_HI   3
`define BL_STAT_FADING    4
`define BL_STAT_RST_HELD  5

// Field layouts
`define BL_FADE_IN_HI     3
`define BL_FADE_IN_LO     0
`define BL_FADE_OUT_HI    7
`define BL_FADE_OUT_LO    4
`define BL_LEVEL_HI       6
`define BL_LAW_HI         1

// Reset values
`define BL_RST_MODE       8'h00
`define BL_RST_FADE       8'h00
`define BL_RST_LAW        8'h00
`define BL_RST_SINK_EN    8'h7f
`define BL_RST_LEVEL      8'h00

// Transfer laws
`define BL_LAW_LINEAR     2'h0
`define BL_LAW_SQUARE     2'h1
`define BL_LAW_CUBIC10    2'h2
`define BL_LAW_CUBIC11    2'h3

// Charge-pump gains
`define BL_GAIN_1X        2'h0
`define BL_GAIN_15X       2'h1
`define BL_GAIN_2X        2'h2

// Timing
`define BL_CLK_MHZ        200
`define BL_SETTLE_US      100
`define BL_RST_FILT_US    50
`define BL_FADE_UNIT_MS   100
`define BL_CODE_FULL      7'h7f
`define BL_KHZ_PER_MHZ    1000

// Fade rates in units of 0.1 s per full scale
`define BL_RATE_0         6'h01
`define BL_RATE_1         6'h03
`define BL_RATE_2         6'h06
`define BL_RATE_3         6'h09
`define BL_RATE_4         6'h0c
`define BL_RATE_5         6'h0f
`define BL_RATE_6         6'h12
`define BL_RATE_7         6'h15
`define BL_RATE_8         6'h18
`define BL_RATE_9         6'h1b
`define BL_RATE_10        6'h1e
`define BL_RATE_11        6'h23
`define BL_RATE_12        6'h28
`define BL_RATE_13        6'h2d
`define BL_RATE_14        6'h32
`define BL_RATE_15        6'h37

// Cubic step stretch at low codes
`define BL_CUBIC_LOW      7'h20
`define BL_CUBIC_MID      7'h40
`define BL_C10_LOW_MULT   3'h4
`define BL_C10_MID_MULT   3'h2
`define BL_C11_LOW_MULT   3'h6
`define BL_C11_MID_MULT   3'h3
`define BL_UNIT_MULT      3'h1

`endif

// file: verilog/bl_gain_sel.v
`include "bl_regs.vh"

module bl_gain_sel
#(
  parameter [15:0] SETTLE_CYC = 16'h4e20
)
(
  input  wire       core_clk,
  input  wire       resetn,
  input  wire       run,
  input  wire       out_ready,
  input  wire [6:0] sink_en,
  input  wire [6:0] sink_low,
  input  wire [6:0] sink_high,
  output reg  [1:0] gain,
  output reg        precharge
);

  localparam [1:0] ST_OFF    = 2'h0;
  localparam [1:0] ST_SS     = 2'h1;
  localparam [1:0] ST_RUN    = 2'h2;
  localparam [1:0] ST_SETTLE = 2'h3;

  reg  [1:0]  state;
  reg  [15:0] settle_cnt;
  wire        any_low;
  wire        all_high;

  // Disabled sinks never vote
  assign any_low  = |(sink_low & sink_en);
  assign all_high = (sink_en != 7'h00) &&
                    ((sink_high & sink_en) == sink_en);

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state      <= ST_OFF;
      gain       <= `BL_GAIN_1X;
      precharge  <= 1'b0;
      settle_cnt <= 16'h0000;
    end
    else if (!run)
    begin
      // Leaving standby always restarts from precharge
      state      <= ST_OFF;
      gain       <= `BL_GAIN_1X;
      precharge  <= 1'b0;
      settle_cnt <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_OFF:
        begin
          state     <= ST_SS;
          precharge <= 1'b1;
        end
        ST_SS:
        begin
          if (out_ready)
          begin
            precharge <= 1'b0;
            gain      <= `BL_GAIN_1X;
            state     <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (any_low && gain != `BL_GAIN_2X)
          begin
            gain       <= gain + 2'h1;
            settle_cnt <= 16'h0000;
            state      <= ST_SETTLE;
          end
          else if (all_high && gain != `BL_GAIN_1X)
          begin
            gain       <= gain - 2'h1;
            settle_cnt <= 16'h0000;
            state      <= ST_SETTLE;
          end
        end
        ST_SETTLE:
        begin
          // Output needs time to move before headroom is trusted again
          if (settle_cnt == SETTLE_CYC - 16'h0001)
            state <= ST_RUN;
          else
            settle_cnt <= settle_cnt + 16'h0001;
        end
        default:
        begin
          state <= ST_OFF;
        end
      endcase
    end
  end

endmodule // bl_gain_sel

// file: verilog/bl_backlight_ctrl.v
`include "bl_regs.vh"

module bl_backlight_ctrl
#(
  parameter [15:0] SETTLE_CYC   = `BL_SETTLE_US * `BL_CLK_MHZ,
  parameter [13:0] RST_FILT_CYC = `BL_RST_FILT_US * `BL_CLK_MHZ,
  parameter [20:0] FADE_TICK    = (`BL_FADE_UNIT_MS * `BL_KHZ_PER_MHZ *
                                   `BL_CLK_MHZ) / 127
)
(
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        hw_reset_pin_low,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_ack,
  input  wire [6:0]  sink_low,
  input  wire [6:0]  sink_high,
  input  wire        out_ready,
  output wire [1:0]  gain,
  output wire        precharge_current,
  output reg         standby,
  output reg  [6:0]  sink_enable,
  output reg  [6:0]  backlight_code,
  output reg  [13:0] sink_level
);

  reg  [7:0]  mode_control_reg;
  reg  [7:0]  fade_rate_config;
  reg  [7:0]  transfer_law_config;
  reg  [7:0]  sink_enable_config;
  reg  [7:0]  backlight_max_level;
  reg  [7:0]  backlight_dim_level;

  reg  [13:0] rst_cnt;
  reg         rst_held;
  reg         run;
  reg  [6:0]  cur_code;
  reg  [26:0] step_cnt;

  wire        active_request;
  wire        backlight_on;
  wire        dim_select;
  wire [1:0]  law;
  wire [6:0]  target;
  wire        rising;
  wire [3:0]  rate_idx;
  wire [26:0] step_len;
  wire        fading;
  reg  [7:0]  next_rdata;

  function [5:0] rate_units;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    rate_units = `BL_RATE_0;
        4'h1:    rate_units = `BL_RATE_1;
        4'h2:    rate_units = `BL_RATE_2;
        4'h3:    rate_units = `BL_RATE_3;
        4'h4:    rate_units = `BL_RATE_4;
        4'h5:    rate_units = `BL_RATE_5;
        4'h6:    rate_units = `BL_RATE_6;
        4'h7:    rate_units = `BL_RATE_7;
        4'h8:    rate_units = `BL_RATE_8;
        4'h9:    rate_units = `BL_RATE_9;
        4'ha:    rate_units = `BL_RATE_10;
        4'hb:    rate_units = `BL_RATE_11;
        4'hc:    rate_units = `BL_RATE_12;
        4'hd:    rate_units = `BL_RATE_13;
        4'he:    rate_units = `BL_RATE_14;
        default: rate_units = `BL_RATE_15;
      endcase
    end
  endfunction

  // Cubic laws dwell longer per step at low codes
  function [2:0] cubic_mult;
    input [1:0] l;
    input [6:0] c;
    begin
      if (l == `BL_LAW_CUBIC10)
      begin
        if (c < `BL_CUBIC_LOW)
          cubic_mult = `BL_C10_LOW_MULT;
        else if (c < `BL_CUBIC_MID)
          cubic_mult = `BL_C10_MID_MULT;
        else
          cubic_mult = `BL_UNIT_MULT;
      end
      else if (l == `BL_LAW_CUBIC11)
      begin
        if (c < `BL_CUBIC_LOW)
          cubic_mult = `BL_C11_LOW_MULT;
        else if (c < `BL_CUBIC_MID)
          cubic_mult = `BL_C11_MID_MULT;
        else
          cubic_mult = `BL_UNIT_MULT;
      end
      else
        cubic_mult = `BL_UNIT_MULT;
    end
  endfunction

  // Sink level on a common scale of 127 * 127 for full scale
  function [13:0] law_level;
    input [6:0] c;
    input [1:0] l;
    begin
      if (l == `BL_LAW_LINEAR)
        law_level = c * `BL_CODE_FULL;
      else
        law_level = c * c;
    end
  endfunction

  assign active_request = mode_control_reg[`BL_MODE_ACTIVE];
  assign backlight_on   = mode_control_reg[`BL_MODE_BL_ON];
  assign dim_select     = mode_control_reg[`BL_MODE_DIM];
  assign law            = transfer_law_config[`BL_LAW_HI:0];

  // Dim above maximum is allowed; the host keeps them ordered
  assign target = (run && backlight_on) ?
                  (dim_select ?
                   backlight_dim_level[`BL_LEVEL_HI:0] :
                   backlight_max_level[`BL_LEVEL_HI:0]) :
                  7'h00;

  assign rising   = target > cur_code;
  assign rate_idx = rising ?
                    fade_rate_config[`BL_FADE_IN_HI:`BL_FADE_IN_LO] :
                    fade_rate_config[`BL_FADE_OUT_HI:`BL_FADE_OUT_LO];
  assign step_len = rate_units(rate_idx) * FADE_TICK *
                    cubic_mult(law, cur_code);
  assign fading   = cur_code != target;

  // Reset pin filter: any high sample restarts the count
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_cnt  <= 14'h0000;
      rst_held <= 1'b0;
    end
    else if (!hw_reset_pin_low)
    begin
      if (!rst_held)
      begin
        if (rst_cnt == RST_FILT_CYC - 14'h0001)
          rst_held <= 1'b1;
        else
          rst_cnt <= rst_cnt + 14'h0001;
      end
    end
    else
    begin
      rst_cnt  <= 14'h0000;
      rst_held <= 1'b0;
    end
  end

  // Register file; POR and a held reset pin both force defaults
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_control_reg    <= `BL_RST_MODE;
      fade_rate_config    <= `BL_RST_FADE;
      transfer_law_config <= `BL_RST_LAW;
      sink_enable_config  <= `BL_RST_SINK_EN;
      backlight_max_level <= `BL_RST_LEVEL;
      backlight_dim_level <= `BL_RST_LEVEL;
    end
    else if (rst_held)
    begin
      mode_control_reg    <= `BL_RST_MODE;
      fade_rate_config    <= `BL_RST_FADE;
      transfer_law_config <= `BL_RST_LAW;
      sink_enable_config  <= `BL_RST_SINK_EN;
      backlight_max_level <= `BL_RST_LEVEL;
      backlight_dim_level <= `BL_RST_LEVEL;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `BL_ADDR_MODE:    mode_control_reg    <= reg_wdata;
        `BL_ADDR_FADE:    fade_rate_config    <= reg_wdata;
        `BL_ADDR_LAW:     transfer_law_config <= reg_wdata;
        `BL_ADDR_SINK_EN: sink_enable_config  <= reg_wdata;
        `BL_ADDR_MAX:     backlight_max_level <= reg_wdata;
        `BL_ADDR_DIM:     backlight_dim_level <= reg_wdata;
        default:          mode_control_reg    <= mode_control_reg;
      endcase
    end
  end

  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `BL_ADDR_MODE:    next_rdata = mode_control_reg;
      `BL_ADDR_FADE:    next_rdata = fade_rate_config;
      `BL_ADDR_LAW:     next_rdata = transfer_law_config;
      `BL_ADDR_SINK_EN: next_rdata = sink_enable_config;
      `BL_ADDR_MAX:     next_rdata = backlight_max_level;
      `BL_ADDR_DIM:     next_rdata = backlight_dim_level;
      `BL_ADDR_STATUS:
      begin
        next_rdata[`BL_STAT_STANDBY]   = standby;
        next_rdata[`BL_STAT_PRECHARGE] = precharge_current;
        next_rdata[`BL_STAT_GAIN_LO]   = gain[0];
        next_rdata[`BL_STAT_GAIN_HI]   = gain[1];
        next_rdata[`BL_STAT_FADING]    = fading;
        next_rdata[`BL_STAT_RST_HELD]  = rst_held;
      end
      `BL_ADDR_CODE:    next_rdata = {1'b0, cur_code};
      default:          next_rdata = 8'h00;
    endcase
  end

  // Access answer; a held reset pin silences it entirely
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_ack   <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_ack <= (reg_wr | reg_rd) & ~rst_held;
      if (reg_rd && !rst_held)
        reg_rdata <= next_rdata;
    end
  end

  // Operating mode
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run         <= 1'b0;
      standby     <= 1'b1;
      sink_enable <= 7'h00;
    end
    else
    begin
      run         <= active_request & ~rst_held;
      standby     <= ~(active_request & ~rst_held);
      sink_enable <= sink_enable_config[6:0] &
                     {7{active_request & ~rst_held}};
    end
  end

  // Fade engine
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_code <= 7'h00;
      step_cnt <= 27'h000_0000;
    end
    else if (rate_idx == 4'h0)
    begin
      // Rate code 0, the fastest-coded setting, means no fade: jump at once
      cur_code <= target;
      step_cnt <= 27'h000_0000;
    end
    else if (!fading)
      step_cnt <= 27'h000_0000;
    else if (step_cnt >= step_len - 27'h000_0001)
    begin
      step_cnt <= 27'h000_0000;
      if (rising)
        cur_code <= cur_code + 7'h01;
      else
        cur_code <= cur_code - 7'h01;
    end
    else
      step_cnt <= step_cnt + 27'h000_0001;
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      backlight_code <= 7'h00;
      sink_level     <= 14'h0000;
    end
    else
    begin
      backlight_code <= cur_code;
      sink_level     <= law_level(cur_code, law);
    end
  end

  bl_gain_sel
  #(
    .SETTLE_CYC (SETTLE_CYC)
  )
  u_gain
  (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .run       (run),
    .out_ready (out_ready),
    .sink_en   (sink_enable),
    .sink_low  (sink_low),
    .sink_high (sink_high),
    .gain      (gain),
    .precharge (precharge_current)
  );

endmodule // bl_backlight_ctrl

// file: verification/bl_backlight_chk.sv
module bl_backlight_chk
#(
  parameter [15:0] SETTLE_CYC   = 16'h0010,
  parameter [13:0] RST_FILT_CYC = 14'h0008
)
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       hw_reset_pin_low,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  input wire logic       out_ready,
  input wire logic [1:0] gain,
  input wire logic       precharge_current,
  input wire logic       standby,
  input wire logic [6:0] sink_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] since;
  logic [13:0] low_cnt;
  logic [1:0]  gain_q;

  // Counters saturate so a long quiet spell never wraps into a false hit
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      since   <= 16'hffff;
      low_cnt <= 14'h0000;
      gain_q  <= 2'h0;
    end
    else
    begin
      gain_q  <= gain;
      since   <= (gain != gain_q) ? 16'h0001 :
                 (since == 16'hffff) ? since : since + 16'h0001;
      low_cnt <= hw_reset_pin_low ? 14'h0000 :
                 (low_cnt == 14'h3fff) ? low_cnt : low_cnt + 14'h0001;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_gain_steps;
    gain != 2'h3 && !(gain == 2'h2 && $past(gain) == 2'h0);
  endproperty
  a_gain_steps: assert property (p_gain_steps)
    else $error("gain left the three steps or skipped one");

  property p_settle;
    (gain != gain_q) && gain != 2'h0 && !standby |-> since >= SETTLE_CYC;
  endproperty
  a_settle: assert property (p_settle)
    else $error("gain changed before settling time");

  property p_precharge_end;
    precharge_current && out_ready |=> !precharge_current && gain == 2'h0;
  endproperty
  a_precharge_end: assert property (p_precharge_end)
    else $error("soft start did not hand over to unity gain");

  property p_ack_taken;
    (reg_wr || reg_rd) && low_cnt < RST_FILT_CYC |=> reg_ack;
  endproperty
  a_ack_taken: assert property (p_ack_taken)
    else $error("access not acknowledged");

  property p_no_ack_held;
    (reg_wr || reg_rd) && low_cnt >= RST_FILT_CYC
      |=> !reg_ack && $stable(reg_rdata);
  endproperty
  a_no_ack_held: assert property (p_no_ack_held)
    else $error("access answered while reset pin held");

  property p_ack_idle;
    !(reg_wr || reg_rd) |=> !reg_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("acknowledge without request");

  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  property p_standby_pin;
    low_cnt >= RST_FILT_CYC |-> ##[1:3] standby;
  endproperty
  a_standby_pin: assert property (p_standby_pin)
    else $error("held reset pin did not force standby");

  property p_sinks_off;
    standby [*3] |-> sink_enable == 7'h00;
  endproperty
  a_sinks_off: assert property (p_sinks_off)
    else $error("sinks enabled in standby");
endmodule // bl_backlight_chk

bind bl_backlight_ctrl bl_backlight_chk
  #(.SETTLE_CYC(SETTLE_CYC), .RST_FILT_CYC(RST_FILT_CYC)) bl_backlight_chk_i
  (.core_clk(core_clk), .resetn(resetn), .hw_reset_pin_low(hw_reset_pin_low),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .out_ready(out_ready), .gain(gain),
   .precharge_current(precharge_current), .standby(standby),
   .sink_enable(sink_enable));

// file: verification/bl_analog_model.sv
module bl_analog_model
#(
  parameter int PRE_CYC = 10
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        precharge_current,
  input  wire logic        standby,
  input  wire logic [1:0]  gain,
  input  wire logic [13:0] need,
  output logic             out_ready,
  output logic [6:0]       sink_low,
  output logic [6:0]       sink_high
);
  timeunit 1ns;
  timeprecision 100ps;
  int chg;

  // Output only charges from the soft-start source and collapses in standby
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      chg <= 0;
    else if (standby)
      chg <= 0;
    else if (precharge_current && chg < PRE_CYC)
      chg <= chg + 1;
  end
  assign out_ready = (chg >= PRE_CYC);

  // Comparators see every sink; masking disabled ones is the device's job
  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      sink_low[i]  = need[2*i +: 2] > gain;
      sink_high[i] = need[2*i +: 2] < gain;
    end
  end
endmodule // bl_analog_model

// file: verification/tb.sv
`include "bl_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [15:0] SETTLE = 16'h0010;
  logic        core_clk, resetn, pin, reg_wr, reg_rd, reg_ack;
  logic        out_ready, precharge, standby;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [6:0]  sink_low, sink_high, sink_enable, code;
  logic [1:0]  gain;
  logic [13:0] sink_level, need;
  int          err_count, n_compared, cyc, n, lo, hi;
  int          u[16] = '{1,3,6,9,12,15,18,21,24,27,30,35,40,45,50,55};

  bl_backlight_ctrl #(.SETTLE_CYC(SETTLE), .RST_FILT_CYC(14'h0008),
    .FADE_TICK(21'h0_0002)) bl_backlight_ctrl_i
    (.core_clk(core_clk), .resetn(resetn), .hw_reset_pin_low(pin),
     .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
     .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
     .sink_low(sink_low), .sink_high(sink_high), .out_ready(out_ready),
     .gain(gain), .precharge_current(precharge), .standby(standby),
     .sink_enable(sink_enable), .backlight_code(code),
     .sink_level(sink_level));

  bl_analog_model #(.PRE_CYC(10)) bl_analog_model_i
    (.core_clk(core_clk), .resetn(resetn), .precharge_current(precharge),
     .standby(standby), .gain(gain), .need(need), .out_ready(out_ready),
     .sink_low(sink_low), .sink_high(sink_high));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Ceiling is about three and a half times the expected run
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 24000)
    begin
      err_count++;
      $display("[FAIL] %0t run did not finish", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic tk(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // One register access; ea is whether an acknowledge is expected
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic ea, input logic [7:0] exp);
    tk(1);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    tk(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chk(16'(reg_ack), 16'(ea), "acknowledge");
    if (!wr && ea)
      chk(16'(reg_rdata), 16'(exp), "read data");
  endtask

  // Bounded wait: sel 0 code, 1 gain, 2 precharge
  task automatic wt(input int sel, input logic [6:0] v, input int lim);
    n = 0;
    while (((sel == 0) ? code : (sel == 1) ? {5'h00, gain} :
            {6'h00, precharge}) !== v && n < lim)
    begin
      tk(1);
      n++;
    end
  endtask

  initial
  begin
    resetn = 1'b0;
    pin = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    need = 14'h0000;
    tk(8);
    resetn = 1'b1;
    chk(16'(standby), 16'h0001, "standby after reset");
    chk(16'(gain), 16'h0000, "gain after reset");
    acc(0, `BL_ADDR_MODE, 8'h00, 1, `BL_RST_MODE);
    acc(0, `BL_ADDR_LAW, 8'h00, 1, `BL_RST_LAW);
    acc(0, `BL_ADDR_SINK_EN, 8'h00, 1, `BL_RST_SINK_EN);
    acc(0, 8'h20, 8'h00, 1, 8'h00);
    acc(1, `BL_ADDR_MAX, 8'h0b, 1, 8'h00);
    acc(1, `BL_ADDR_DIM, 8'h05, 1, 8'h00);
    acc(0, `BL_ADDR_MAX, 8'h00, 1, 8'h0b);
    acc(0, `BL_ADDR_DIM, 8'h00, 1, 8'h05);
    acc(1, `BL_ADDR_MODE, 8'h03, 1, 8'h00);
    wt(2, 7'h01, 20);
    chk(16'(precharge), 16'h0001, "soft start");
    wt(0, 7'h0b, 100);
    chk(16'(sink_level), 16'h0575, "linear level");
    chk(16'(standby), 16'h0000, "active");
    for (int l = 1; l < 4; l++)
    begin
      acc(1, `BL_ADDR_LAW, 8'(l), 1, 8'h00);
      tk(3);
      chk(16'(sink_level), 16'h0079, "square level");
    end
    acc(1, `BL_ADDR_MODE, 8'h07, 1, 8'h00);
    wt(0, 7'h05, 50);
    chk(16'(sink_level), 16'h0019, "dim level");
    acc(1, `BL_ADDR_MODE, 8'h03, 1, 8'h00);
    wt(0, 7'h0b, 50);
    chk(16'(code), 16'h000b, "back to max");
    acc(1, `BL_ADDR_LAW, 8'h00, 1, 8'h00);
    acc(1, `BL_ADDR_MAX, 8'h04, 1, 8'h00);
    for (int r = 0; r < 16; r++)
    begin
      lo = (r == 0) ? 0 : 6 * u[r] - 3;
      hi = (r == 0) ? 3 : 8 * u[r] + 4;
      acc(1, `BL_ADDR_FADE, {r[3:0], r[3:0]}, 1, 8'h00);
      acc(1, `BL_ADDR_MODE, 8'h03, 1, 8'h00);
      wt(0, 7'h04, 1000);
      chk(16'(n >= lo && n <= hi), 16'h0001, "fade in time");
      acc(1, `BL_ADDR_MODE, 8'h01, 1, 8'h00);
      wt(0, 7'h00, 1000);
      chk(16'(n >= lo && n <= hi), 16'h0001, "fade out time");
    end
    // Cubic fade stretches steps at low codes; fade out uses its own field
    acc(1, `BL_ADDR_FADE, 8'h01, 1, 8'h00);
    acc(1, `BL_ADDR_LAW, {6'h00, `BL_LAW_CUBIC10}, 1, 8'h00);
    acc(1, `BL_ADDR_MODE, 8'h03, 1, 8'h00);
    lo = 6 * u[1] * `BL_C10_LOW_MULT;
    hi = 8 * u[1] * `BL_C10_LOW_MULT + 4;
    wt(0, 7'h04, 1000);
    chk(16'(n >= lo && n <= hi), 16'h0001, "cubic fade time");
    acc(0, `BL_ADDR_CODE, 8'h00, 1, 8'h04);
    acc(1, `BL_ADDR_MODE, 8'h01, 1, 8'h00);
    wt(0, 7'h00, 50);
    chk(16'(n <= 3), 16'h0001, "fade out field");
    need = 14'h0002;
    wt(1, 7'h01, 100);
    chk(16'(gain), 16'h0001, "gain up once");
    wt(1, 7'h02, 100);
    chk(16'(gain), 16'h0002, "gain up twice");
    chk(16'(n >= SETTLE && n <= SETTLE + 3), 16'h0001, "settling gap");
    need = 14'h0000;
    wt(1, 7'h00, 100);
    chk(16'(gain), 16'h0000, "gain back down");
    acc(1, `BL_ADDR_SINK_EN, 8'h7e, 1, 8'h00);
    need = 14'h0002;
    tk(60);
    chk(16'(gain), 16'h0000, "disabled sink ignored");
    chk(16'(sink_enable), 16'h007e, "sink enables");
    pin = 1'b0;
    tk(5);
    pin = 1'b1;
    acc(0, `BL_ADDR_MAX, 8'h00, 1, 8'h04);
    pin = 1'b0;
    tk(20);
    chk(16'(standby), 16'h0001, "standby on pin");
    acc(0, `BL_ADDR_MAX, 8'h00, 0, 8'h00);
    acc(1, `BL_ADDR_MAX, 8'h7f, 0, 8'h00);
    pin = 1'b1;
    tk(2);
    acc(0, `BL_ADDR_MAX, 8'h00, 1, `BL_RST_LEVEL);
    acc(0, `BL_ADDR_SINK_EN, 8'h00, 1, `BL_RST_SINK_EN);
    acc(0, `BL_ADDR_STATUS, 8'h00, 1, 8'(1 << `BL_STAT_STANDBY));
    chk(16'(standby), 16'h0001, "standby after release");
    acc(1, `BL_ADDR_MODE, 8'h01, 1, 8'h00);
    wt(2, 7'h01, 20);
    chk(16'(precharge), 16'h0001, "soft start again");
    wt(2, 7'h00, 50);
    chk(16'(gain), 16'h0000, "unity after soft start");
    acc(1, `BL_ADDR_MODE, 8'h00, 1, 8'h00);
    tk(3);
    chk(16'(standby), 16'h0001, "standby on clear");
    acc(1, `BL_ADDR_MAX, 8'h7f, 1, 8'h00);
    resetn = 1'b0;
    tk(2);
    resetn = 1'b1;
    acc(0, `BL_ADDR_MAX, 8'h00, 1, `BL_RST_LEVEL);
    chk(16'(standby), 16'h0001, "standby after supply start");
    give_verdict();
  end
endmodule // tb
